/* dsb_params.svh */
// Constants for the two-word-burst memory bus port
`ifndef DSB_PARAMS_SVH
`define DSB_PARAMS_SVH
`define DSB_DATA_W     36
`define DSB_ADDR_W     8
`define DSB_DEPTH      256
`define DSB_LANES      4
`define DSB_LANE_W     9
`define DSB_RD_LAT     2
`define DSB_LAT_W      2
`define DSB_ORG_X8     2'h0
`define DSB_ORG_X9     2'h1
`define DSB_ORG_X18    2'h2
`define DSB_ORG_X36    2'h3
`endif

/* dsb_pkg.sv */
// Types for the two-word-burst memory bus port
`include "dsb_params.svh"
package dsb_pkg;
  typedef enum logic [1:0] {
    DSB_IDLE  = 2'b00,
    DSB_WR2   = 2'b01,
    DSB_RDW   = 2'b10
  } dsb_phase_t;

  typedef struct packed {
    logic                    load_strobe_n;
    logic                    read_not_write;
    logic [`DSB_ADDR_W-1:0]  word_addr;
    logic                    burst_start_word_bit;
  } dsb_cmd_t;

  typedef struct packed {
    logic [`DSB_DATA_W-1:0]  data;
    logic                    drive;
  } dsb_dout_t;

  typedef struct packed {
    dsb_phase_t              phase;
    logic [`DSB_ADDR_W-1:0]  wr_addr;
    logic                    wr_first;
    logic [`DSB_LANES-1:0]   wr_sel_n;
    logic [`DSB_DATA_W-1:0]  wr_word0;
    logic [`DSB_RD_LAT-1:0]  rd_pipe;
    logic [`DSB_ADDR_W-1:0]  rd_addr;
    logic                    rd_first;
    logic                    rd_second;
    logic [`DSB_DATA_W-1:0]  rd_word1;
    logic [`DSB_DATA_W-1:0]  dout;
    logic                    drive;
    logic                    echo;
  } dsb_state_t;
endpackage

/* dsb_port.sv */
// Device-side bus port of a two-word-burst double-data-rate static memory
`include "dsb_params.svh"
module dsb_port
  import dsb_pkg::*;
(
  // Clock and reset; internal clock is the true input clock, doubled words
  input  wire logic                   clock,
  input  wire logic                   resetn,
  // Organisation select
  input  wire logic [1:0]             org_sel,
  // Command from controller, pins already synchronised two deep below
  input  wire dsb_pkg::dsb_cmd_t      cmd,
  input  wire logic [`DSB_LANES-1:0]  byte_write_select_n,
  // Write burst words, first with the command and second one clock later, both sampled on the rising clock edge
  input  wire logic [`DSB_DATA_W-1:0] data_in_true,
  input  wire logic [`DSB_DATA_W-1:0] data_in_comp,
  // Output clock pair, held high to fall back to input clocks
  input  wire logic                   out_clk_true,
  input  wire logic                   out_clk_comp,
  // Data bus, output enable low while driving
  output logic [`DSB_DATA_W-1:0]      data_io_bus_o,
  output logic                        data_io_bus_oe_n,
  output logic                        use_input_clocks,
  // Echo strobes
  output logic                        echo_strobe_true,
  output logic                        echo_strobe_comp
);
  import dsb_pkg::*;

  logic [`DSB_DATA_W-1:0] mem [`DSB_DEPTH];
  dsb_state_t s_q, s_d;
  dsb_cmd_t   cmd_m, cmd_s;
  logic [`DSB_LANES-1:0] sel_m, sel_s;
  logic [`DSB_DATA_W-1:0] dt_m, dt_s, dc_m, dc_s;
  logic [1:0] oc_m, oc_s;
  logic [1:0] org_m, org_s;
  logic       accept, is_read;

  // Lane mask from organisation; x8 uses two nibble selects
  function automatic logic [`DSB_DATA_W-1:0] lane_mask(
    input logic [1:0]            org,
    input logic [`DSB_LANES-1:0] seln);
    logic [`DSB_DATA_W-1:0] m;
    m = '0;
    case (org)
      `DSB_ORG_X8: begin
        m[3:0] = {4{~seln[0]}};
        m[7:4] = {4{~seln[1]}};
      end
      `DSB_ORG_X9: m[8:0] = {9{~seln[0]}};
      `DSB_ORG_X18: begin
        m[8:0]  = {9{~seln[0]}};
        m[17:9] = {9{~seln[1]}};
      end
      default: begin
        for (int i = 0; i < `DSB_LANES; i++) begin
          m[i*`DSB_LANE_W +: `DSB_LANE_W] = {`DSB_LANE_W{~seln[i]}};
        end
      end
    endcase
    return m;
  endfunction

  // Unused data lines read as zero per organisation
  function automatic logic [`DSB_DATA_W-1:0] width_mask(input logic [1:0] org);
    return lane_mask(org, '0);
  endfunction

  // Two-stage synchronisers on all pins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_m <= '{load_strobe_n: 1'b1, default: '0};
      cmd_s <= '{load_strobe_n: 1'b1, default: '0};
      sel_m <= '1;
      sel_s <= '1;
      dt_m  <= '0;
      dt_s  <= '0;
      dc_m  <= '0;
      dc_s  <= '0;
      oc_m  <= 2'h3;
      oc_s  <= 2'h3;
      org_m <= `DSB_ORG_X36;
      org_s <= `DSB_ORG_X36;
    end else begin
      cmd_m <= cmd;
      cmd_s <= cmd_m;
      sel_m <= byte_write_select_n;
      sel_s <= sel_m;
      dt_m  <= data_in_true;
      dt_s  <= dt_m;
      dc_m  <= data_in_comp;
      dc_s  <= dc_m;
      oc_m  <= {out_clk_true, out_clk_comp};
      oc_s  <= oc_m;
      // Strap level; changing it while a burst is in flight is not supported
      org_m <= org_sel;
      org_s <= org_m;
    end
  end

  assign accept  = !cmd_s.load_strobe_n;
  assign is_read = cmd_s.read_not_write;

  always_comb begin
    s_d = s_q;
    s_d.echo = ~s_q.echo;
    s_d.rd_pipe = {s_q.rd_pipe[`DSB_RD_LAT-2:0], 1'b0};
    s_d.drive = 1'b0;
    s_d.rd_second = 1'b0;
    s_d.phase = DSB_IDLE;
    // Lines rest at zero so an organisation change leaves no stale upper bits
    s_d.dout = '0;
    // First read word, then second on next cycle
    // One word per clock: reads closer than two cycles apart would overlap
    if (s_q.rd_pipe[`DSB_RD_LAT-1]) begin
      s_d.dout = mem[s_q.rd_addr] & width_mask(org_s);
      s_d.drive = 1'b1;
      s_d.rd_second = 1'b1;
      s_d.phase = DSB_RDW;
    end else if (s_q.rd_second) begin
      s_d.dout = s_q.rd_word1 & width_mask(org_s);
      s_d.drive = 1'b1;
    end
    if (accept) begin
      if (is_read) begin
        s_d.rd_pipe[0] = 1'b1;
        // Start word may be either one on wide organisations
        s_d.rd_addr = {cmd_s.word_addr[`DSB_ADDR_W-1:1],
                       (org_s[1] ? cmd_s.burst_start_word_bit : 1'b0)};
      end else begin
        s_d.phase = DSB_WR2;
        s_d.wr_addr = {cmd_s.word_addr[`DSB_ADDR_W-1:1],
                       (org_s[1] ? cmd_s.burst_start_word_bit : 1'b0)};
        s_d.wr_sel_n = sel_s;
        s_d.wr_word0 = dt_s;
      end
    end
    s_d.rd_word1 = mem[{s_q.rd_addr[`DSB_ADDR_W-1:1], ~s_q.rd_addr[0]}] & width_mask(org_s);
  end

  // Both burst words written one cycle after command, masked by lanes
  always_ff @(posedge clock) begin
    if (s_q.phase == DSB_WR2) begin
      mem[s_q.wr_addr] <= (mem[s_q.wr_addr] & ~lane_mask(org_s, s_q.wr_sel_n))
                        | (s_q.wr_word0 & lane_mask(org_s, s_q.wr_sel_n));
      mem[{s_q.wr_addr[`DSB_ADDR_W-1:1], ~s_q.wr_addr[0]}] <=
        (mem[{s_q.wr_addr[`DSB_ADDR_W-1:1], ~s_q.wr_addr[0]}]
         & ~lane_mask(org_s, sel_s))
        | (dc_s & lane_mask(org_s, sel_s));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{phase: DSB_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign data_io_bus_o    = s_q.dout;
  assign data_io_bus_oe_n = ~s_q.drive;
  assign use_input_clocks = &oc_s;
  assign echo_strobe_true = s_q.echo;
  assign echo_strobe_comp = ~s_q.echo;

  // Read word appears exactly at the fixed latency
  rd_latency_a: assert property (@(posedge clock) disable iff (!resetn)
    accept && is_read |-> ##(`DSB_RD_LAT+1) !data_io_bus_oe_n)
    else $error("read word late");
  rd_two_words_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(data_io_bus_oe_n) |=> !data_io_bus_oe_n)
    else $error("read burst not two words");
  nop_no_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    (s_q.rd_pipe == '0 && !s_q.rd_second) |=> data_io_bus_oe_n)
    else $error("bus driven without read");
  wr_phase_a: assert property (@(posedge clock) disable iff (!resetn)
    accept && !is_read |=> s_q.phase == DSB_WR2)
    else $error("write not started");
  echo_toggle_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> echo_strobe_true != $past(echo_strobe_true))
    else $error("echo stalled");
  echo_pair_a: assert property (@(posedge clock) disable iff (!resetn)
    echo_strobe_comp == ~echo_strobe_true)
    else $error("echo pair skewed");
  no_drive_wr_a: assert property (@(posedge clock) disable iff (!resetn)
    accept && !is_read && s_q.rd_pipe == '0 && !s_q.rd_second |=> data_io_bus_oe_n)
    else $error("driven on write");
  width_a: assert property (@(posedge clock) disable iff (!resetn)
    (data_io_bus_o & ~width_mask(org_s)) == '0 || !$stable(org_s))
    else $error("unused lines set");
  ref_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    out_clk_true && out_clk_comp |-> ##2 use_input_clocks)
    else $error("clock reference wrong");
  ref_out_a: assert property (@(posedge clock) disable iff (!resetn)
    !(out_clk_true && out_clk_comp) |-> ##2 !use_input_clocks)
    else $error("output clock reference lost");
  idle_no_write_a: assert property (@(posedge clock) disable iff (!resetn)
    !accept |=> s_q.phase != DSB_WR2)
    else $error("idle cycle wrote");

  cov_read_c:  cover property (@(posedge clock) disable iff (!resetn) accept && is_read);
  cov_write_c: cover property (@(posedge clock) disable iff (!resetn) accept && !is_read);
  cov_b2b_c:   cover property (@(posedge clock) disable iff (!resetn) accept ##1 accept);
  cov_start1_c: cover property (@(posedge clock) disable iff (!resetn)
    accept && cmd_s.burst_start_word_bit);
  cov_narrow_c: cover property (@(posedge clock) disable iff (!resetn)
    accept && !org_s[1]);
endmodule // dsb_port

/* dsb_ctl_model.sv */
// Controller-side model that drives the burst memory bus port
`include "dsb_params.svh"
module dsb_ctl_model
  import dsb_pkg::*;
(
  // Clock and returned read data
  input  wire logic                   clock,
  input  wire logic [`DSB_DATA_W-1:0] dq_o,
  input  wire logic                   dq_oe_n,
  // Command, write words and output clock pair
  output dsb_pkg::dsb_cmd_t           cmd,
  output logic [`DSB_LANES-1:0]       sel_n,
  output logic [`DSB_DATA_W-1:0]      wd_t,
  output logic [`DSB_DATA_W-1:0]      wd_c,
  output logic                        oc_t,
  output logic                        oc_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_q = 1'h0;
  initial begin
    cmd = '{1'h1, 1'h0, 8'h00, 1'h0};
    sel_n = 4'hf;
    wd_t = '0;
    wd_c = '0;
  end
  // Pair runs only when asked; otherwise both held high
  initial {oc_t, oc_c} = 2'h3;
  always @(posedge clock) begin
    oc_t <= run_q ? ~oc_t : 1'h1;
    oc_c <= run_q ? oc_t : 1'h1;
  end
  task automatic wr(input logic [7:0] a, input logic sb, input logic [35:0] w0, w1,
                    input logic [3:0] s);
    @(posedge clock);
    cmd <= '{1'h0, 1'h0, a, sb};
    wd_t <= w0;
    sel_n <= s;
    @(posedge clock);
    cmd.load_strobe_n <= 1'h1;
    wd_c <= w1;
    @(posedge clock);
    // Released lines show the inverse so stale data cannot pass
    wd_t <= ~w0;
    wd_c <= ~w1;
    sel_n <= ~s;
  endtask
  task automatic rd(input logic [7:0] a, input logic sb, output logic [35:0] w0, w1,
                    output int lat);
    @(posedge clock);
    cmd <= '{1'h0, 1'h1, a, sb};
    @(posedge clock);
    cmd.load_strobe_n <= 1'h1;
    lat = 99;
    for (int i = 1; i < 20; i++) begin
      @(posedge clock);
      #1;
      if (dq_oe_n === 1'h0) begin
        lat = i;
        break;
      end
    end
    w0 = dq_o;
    @(posedge clock);
    #1;
    w1 = dq_o;
  endtask
  task automatic idle_cycle(input logic [7:0] a);
    @(posedge clock);
    // Write-looking idle with all lanes open; nothing may land
    cmd <= '{1'h1, 1'h0, a, 1'h1};
    sel_n <= 4'h0;
  endtask
endmodule // dsb_ctl_model

/* tb_ddr_sram_burst2_bus_port.sv */
// Self-checking bench for the burst memory bus port
`include "dsb_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_ddr_sram_burst2_bus_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [35:0] WA = 36'h123456789, WB = 36'hfedcba987, WC = 36'h0aa55aa55;
  localparam logic [35:0] LM = 36'h007fc01ff;
  localparam logic [35:0] E0 = (WA & ~LM) | (WC & LM), E1 = (WB & ~LM) | (~WC & LM);
  logic              clock = 1'h0;
  logic              resetn = 1'h0;
  logic [1:0]        org_sel = 2'h3;
  dsb_pkg::dsb_cmd_t cmd;
  logic [3:0]        sel_n;
  logic [35:0]       wd_t, wd_c, dq_o, w0, w1;
  logic              oc_t, oc_c, oe_n, uic, es_t, es_c, e;
  int                checks = 0, mismatches = 0, lat0, lat;
  always #2 clock = ~clock;
  dsb_ctl_model ctl (.clock(clock), .dq_o(dq_o), .dq_oe_n(oe_n), .cmd(cmd), .sel_n(sel_n),
    .wd_t(wd_t), .wd_c(wd_c), .oc_t(oc_t), .oc_c(oc_c));
  dsb_port uut (.clock(clock), .resetn(resetn), .org_sel(org_sel), .cmd(cmd),
    .byte_write_select_n(sel_n), .data_in_true(wd_t), .data_in_comp(wd_c),
    .out_clk_true(oc_t), .out_clk_comp(oc_c), .data_io_bus_o(dq_o),
    .data_io_bus_oe_n(oe_n), .use_input_clocks(uic), .echo_strobe_true(es_t),
    .echo_strobe_comp(es_c));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic sb, input logic [35:0] e0, e1);
    ctl.rd(a, sb, w0, w1, lat);
    if (lat == 99) begin
      mismatches++;
      finish_test;
    end else begin
      `CHK("first word", e0, w0)
      `CHK("second word", e1, w1)
      @(posedge clock);
      #1;
      `CHK("bus released", 1'h1, oe_n)
    end
  endtask
  task automatic t_echo;
    @(posedge clock);
    #1;
    e = es_t;
    @(posedge clock);
    #1;
    `CHK("echo toggles", ~e, es_t)
    `CHK("echo pair", ~es_t, es_c)
    $display("test echo done");
  endtask
  task automatic t_order;
    ctl.wr(8'h21, 1'h0, WA, WB, 4'h0);
    rdx(8'h21, 1'h0, WA, WB);
    lat0 = lat;
    rdx(8'h21, 1'h1, WB, WA);
    `CHK("latency", lat0, lat)
    `CHK("read latency", `DSB_RD_LAT + 2, lat)
    $display("test order done");
  endtask
  task automatic t_lanes;
    ctl.wr(8'h21, 1'h0, WC, ~WC, 4'ha);
    rdx(8'h21, 1'h0, E0, E1);
    $display("test lanes done");
  endtask
  task automatic t_idle;
    ctl.idle_cycle(8'h21);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      `CHK("idle bus", 1'h1, oe_n)
    end
    $display("test idle done");
  endtask
  task automatic t_org;
    // Start bit ignored on the narrow organisations, honoured on x18
    @(posedge clock);
    org_sel <= 2'h1;
    rdx(8'h21, 1'h1, {27'h0, E0[8:0]}, {27'h0, E1[8:0]});
    @(posedge clock);
    org_sel <= 2'h0;
    rdx(8'h21, 1'h1, {28'h0, E0[7:0]}, {28'h0, E1[7:0]});
    @(posedge clock);
    org_sel <= 2'h2;
    rdx(8'h21, 1'h1, {18'h0, E1[17:0]}, {18'h0, E0[17:0]});
    @(posedge clock);
    org_sel <= 2'h3;
    $display("test org done");
  endtask
  task automatic t_clk;
    @(posedge clock);
    ctl.run_q <= 1'h1;
    repeat (6) @(posedge clock);
    #1;
    `CHK("output clock ref", 1'h0, uic)
    rdx(8'h21, 1'h1, E1, E0);
    @(posedge clock);
    ctl.run_q <= 1'h0;
    repeat (6) @(posedge clock);
    #1;
    `CHK("input clock ref", 1'h1, uic)
    $display("test clocks done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1;
    `CHK("oe in reset", 1'h1, oe_n)
    `CHK("ref in reset", 1'h1, uic)
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    t_echo;
    t_order;
    t_lanes;
    t_idle;
    t_org;
    t_clk;
    finish_test;
  end
endmodule // tb_ddr_sram_burst2_bus_port
